//--- acs_pkg.sv
package acs_pkg;

  // Register byte addresses on the memory-mapped I/O bus
  localparam logic [7:0] ACS_CTRL1_ADDR = 8'h9F;
  localparam logic [7:0] ACS_CTRL2_ADDR = 8'hA0;
  localparam logic [7:0] ACS_RESULT_ADDR = 8'hA1;

  // conversion_control_reg bit positions
  localparam int ACS_C1_DONE = 7;
  localparam int ACS_C1_IRQEN = 6;
  localparam int ACS_C1_BUSY = 5;
  localparam int ACS_C1_REF_SELECT = 4;
  localparam int ACS_C1_CHAN_HI = 3;
  localparam int ACS_C1_CHAN_LO = 0;

  // Reset values, and the SAR code and mask loaded at each trigger
  localparam logic [7:0] ACS_CFG_RESET = 8'h00;
  localparam logic [3:0] ACS_CHAN_RESET = 4'h0;
  localparam logic [7:0] ACS_DATA_RESET = 8'h00;
  localparam logic [7:0] ACS_SAR_FIRST = 8'h80;

  // Phase and whole-conversion lengths in conversion clock cycles
  localparam logic [4:0] ACS_SH_TICKS = 5'h04;
  localparam logic [4:0] ACS_AZ_PRE_TICKS = 5'h0B;
  localparam logic [4:0] ACS_RESOLVE_TICKS = 5'h09;
  localparam logic [4:0] ACS_STD_TOTAL = 5'h0D;
  localparam logic [4:0] ACS_AZ_TOTAL = 5'h14;

  // analog_config_two layout, bit 7 down to bit 0
  typedef struct packed {
    logic ref_clock_halve;
    logic comparator_input_select;
    logic spare_amp_enable;
    logic auto_sample_enable;
    logic [1:0] conv_clock_divider;
    logic current_source_enable;
    logic autozero_enable;
  } acs_cfg_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ACS_IDLE = 4'h1,
    ACS_SAMPLE = 4'h2,
    ACS_RESOLVE = 4'h4,
    ACS_FINISH = 4'h8
  } acs_state_t;

endpackage : acs_pkg

//--- acs_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module acs_tick_gen
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic [1:0] divider,
  output logic tick
);

  logic [2:0] cnt_ff;
  logic tick_ff;

  // Divide factor 1, 2, 4 or 8 expressed as the last count value
  function automatic logic [2:0] acs_last(input logic [1:0] d);
    case (d)
      2'h0: acs_last = 3'h0;
      2'h1: acs_last = 3'h1;
      2'h2: acs_last = 3'h3;
      default: acs_last = 3'h7;
    endcase
  endfunction : acs_last

  // Restart aligns the conversion clock to the trigger instant
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= acs_last(divider)) begin
      cnt_ff <= 3'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule : acs_tick_gen
`default_nettype wire

//--- acs_seq.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Config bit 7 set halves the reference clock, clear passes it through.
// - Config bit 6 picks pin two, else pin zero, for the comparator.
// - Config bit 5 enables spare amplifier; its output feeds channel five.
// - Auto mode aligns conversion clock and starts on strobe rising edge.
// - Without auto mode only software start bit writes begin conversions.
// - Config bits 3:2 divide the conversion clock by 1, 2, 4, 8.
// - Config bit 1 enables the current source on analog pin one.
// - Config bit 0 enables the gain-16 autozero amplifier on pin zero.
// - Autozero enable and channel are captured at trigger, held to end.
// - Default standard mode: one conversion per software start write.
// - Start/busy bit reads one throughout a conversion.
// - Standard conversion: four sample ticks, nine resolve ticks, store result.
// - Autozero conversion lasts twenty conversion clock ticks instead.
// - Result stored and done flag set on the same edge, then busy bit clears.
// - Writing zero to busy during a conversion is ignored.
// - Strobe edges during a conversion are dropped.
// - Writing zero clears done flag; writing one leaves it unchanged.
// - Interrupt follows done flag while interrupt enable is set.
module acs_seq
  import acs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  output logic [7:0] BUS_RDATA,
  input wire logic TIMER_SAMPLE_STROBE,
  input wire logic REF_CLOCK_IN,
  input wire logic COMP_ABOVE,
  output logic REF_CLOCK_OUT,
  output logic COMPARATOR_INPUT_SELECT,
  output logic SPARE_AMP_ENABLE,
  output logic CURRENT_SOURCE_ENABLE,
  output logic AUTOZERO_ACTIVE,
  output logic REF_SELECT,
  output logic [3:0] CHANNEL_ACTIVE,
  output logic SAMPLE_PHASE,
  output logic [7:0] SAR_CODE,
  output logic CONV_IRQ
);

  acs_cfg_t cfg_ff;
  acs_state_t state_ff;
  logic irq_en_ff, ref_sel_ff, done_ff, az_act_ff;
  logic [3:0] chan_ff, chan_act_ff;
  logic [7:0] result_ff, code_ff, mask_ff, rdata_ff;
  logic [4:0] cnt_ff, tick_total_ff;
  logic stb_s1_ff, stb_s2_ff, stb_s3_ff, stb_lvl_ff;
  logic ref_s1_ff, ref_s2_ff, ref_s3_ff, ref_lvl_ff, ref_div_ff;
  logic wr_c1, wr_c2, busy, sw_start, stb_rise, ref_rise, trigger, tick;
  logic set_done, last_sample;

  // Bus decode; result register is read only so writes to it are dropped
  assign wr_c1 = BUS_WR && (BUS_ADDR == ACS_CTRL1_ADDR);
  assign wr_c2 = BUS_WR && (BUS_ADDR == ACS_CTRL2_ADDR);
  assign busy = (state_ff != ACS_IDLE);

  // Start requests: software only in standard mode, strobe only in auto
  assign sw_start = wr_c1 && BUS_WDATA[ACS_C1_BUSY] &&
                    !cfg_ff.auto_sample_enable;
  assign trigger = !busy &&
                   (sw_start || (cfg_ff.auto_sample_enable && stb_rise));
  assign set_done = tick && (state_ff == ACS_RESOLVE) &&
                    (cnt_ff == ACS_RESOLVE_TICKS - 5'h01);
  assign last_sample = cnt_ff == (az_act_ff ? ACS_AZ_PRE_TICKS :
                                  ACS_SH_TICKS) - 5'h01;

  // Strobe pin: three stages, a level change counts once stages 2 and 3 agree
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stb_s1_ff <= 1'b0;
      stb_s2_ff <= 1'b0;
      stb_s3_ff <= 1'b0;
      stb_lvl_ff <= 1'b0;
    end else begin
      stb_s1_ff <= TIMER_SAMPLE_STROBE;
      stb_s2_ff <= stb_s1_ff;
      stb_s3_ff <= stb_s2_ff;
      if (stb_s2_ff == stb_s3_ff) begin
        stb_lvl_ff <= stb_s2_ff;
      end
    end
  end
  assign stb_rise = stb_s2_ff && stb_s3_ff && !stb_lvl_ff;

  // Reference clock: same filtered sampling, halved by a toggle on rises
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
      ref_lvl_ff <= 1'b0;
      ref_div_ff <= 1'b0;
    end else begin
      ref_s1_ff <= REF_CLOCK_IN;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
      if (ref_s2_ff == ref_s3_ff) begin
        ref_lvl_ff <= ref_s2_ff;
      end
      if (ref_rise) begin
        ref_div_ff <= !ref_div_ff;
      end
    end
  end
  assign ref_rise = ref_s2_ff && ref_s3_ff && !ref_lvl_ff;

  // Configuration register, writable at any time
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_ff <= ACS_CFG_RESET;
    end else if (wr_c2) begin
      cfg_ff <= BUS_WDATA;
    end
  end

  // Control fields other than busy and done
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_en_ff <= 1'b0;
      ref_sel_ff <= 1'b0;
      chan_ff <= ACS_CHAN_RESET;
    end else if (wr_c1) begin
      irq_en_ff <= BUS_WDATA[ACS_C1_IRQEN];
      ref_sel_ff <= BUS_WDATA[ACS_C1_REF_SELECT];
      chan_ff <= BUS_WDATA[ACS_C1_CHAN_HI:ACS_C1_CHAN_LO];
    end
  end

  // Done flag: hardware set beats a same-cycle software clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_ff <= 1'b0;
    end else if (set_done) begin
      done_ff <= 1'b1;
    end else if (wr_c1 && !BUS_WDATA[ACS_C1_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // Per-conversion snapshot; a later write shows in the register only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      az_act_ff <= 1'b0;
      chan_act_ff <= ACS_CHAN_RESET;
    end else if (trigger) begin
      az_act_ff <= cfg_ff.autozero_enable;
      chan_act_ff <= sw_start ? BUS_WDATA[ACS_C1_CHAN_HI:ACS_C1_CHAN_LO]
                              : chan_ff;
    end
  end

  // Conversion clock; restarting it on the trigger keeps strobe alignment
  acs_tick_gen u_tick (
    .clk(CLK),
    .resetn(RESETN),
    .restart(trigger),
    .divider(cfg_ff.conv_clock_divider),
    .tick(tick)
  );

  // Sequencer: sample (or autozero) phase, resolve phase, then release busy
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= ACS_IDLE;
      cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        ACS_IDLE: begin
          if (trigger) begin
            state_ff <= ACS_SAMPLE;
            cnt_ff <= 5'h00;
          end
        end
        ACS_SAMPLE: begin
          if (tick && last_sample) begin
            state_ff <= ACS_RESOLVE;
            cnt_ff <= 5'h00;
          end else if (tick) begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
        ACS_RESOLVE: begin
          if (set_done) begin
            state_ff <= ACS_FINISH;
          end else if (tick) begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
        ACS_FINISH: begin
          state_ff <= ACS_IDLE;
        end
        default: begin
          state_ff <= ACS_IDLE;
        end
      endcase
    end
  end

  // Successive approximation: eight trial ticks, the ninth stores the code
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      code_ff <= ACS_DATA_RESET;
      mask_ff <= ACS_DATA_RESET;
      result_ff <= ACS_DATA_RESET;
    end else if (trigger) begin
      code_ff <= ACS_SAR_FIRST;
      mask_ff <= ACS_SAR_FIRST;
    end else if (tick && state_ff == ACS_RESOLVE) begin
      if (set_done) begin
        result_ff <= code_ff;
      end else begin
        code_ff <= (COMP_ABOVE ? code_ff : (code_ff & ~mask_ff)) |
                   (mask_ff >> 1);
        mask_ff <= mask_ff >> 1;
      end
    end
  end

  // Tick count since trigger, read only by the assertions
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick_total_ff <= 5'h00;
    end else if (trigger) begin
      tick_total_ff <= 5'h00;
    end else if (tick && busy) begin
      tick_total_ff <= tick_total_ff + 5'h01;
    end
  end

  // Read data registered: answer appears one cycle after the address
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= ACS_DATA_RESET;
    end else begin
      case (BUS_ADDR)
        ACS_CTRL1_ADDR: rdata_ff <= {done_ff, irq_en_ff, busy,
                                     ref_sel_ff, chan_ff};
        ACS_CTRL2_ADDR: rdata_ff <= cfg_ff;
        ACS_RESULT_ADDR: rdata_ff <= result_ff;
        default: rdata_ff <= ACS_DATA_RESET;
      endcase
    end
  end

  // Analog control outputs from registers; REF_CLOCK_OUT is muxed, SAMPLE_PHASE and CONV_IRQ decoded
  assign BUS_RDATA = rdata_ff;
  assign REF_CLOCK_OUT = cfg_ff.ref_clock_halve ? ref_div_ff
                                                : ref_lvl_ff;
  assign COMPARATOR_INPUT_SELECT = cfg_ff.comparator_input_select;
  assign SPARE_AMP_ENABLE = cfg_ff.spare_amp_enable;
  assign CURRENT_SOURCE_ENABLE = cfg_ff.current_source_enable;
  assign AUTOZERO_ACTIVE = az_act_ff;
  assign REF_SELECT = ref_sel_ff;
  assign CHANNEL_ACTIVE = chan_act_ff;
  assign SAMPLE_PHASE = (state_ff == ACS_SAMPLE);
  assign SAR_CODE = code_ff;
  assign CONV_IRQ = irq_en_ff && done_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_conv_length_ok: assert property (
    set_done |-> tick_total_ff ==
      (az_act_ff ? ACS_AZ_TOTAL : ACS_STD_TOTAL) - 5'h01)
    else $error("conversion length wrong");
  a_az_total_ok: assert property (
    (set_done && az_act_ff) |-> tick_total_ff == ACS_AZ_TOTAL - 5'h01)
    else $error("autozero conversion not twenty ticks");
  a_done_then_idle: assert property (
    set_done |=> done_ff && busy ##1 !busy)
    else $error("busy did not clear after done");
  a_busy_ignores_zero: assert property (
    (wr_c1 && !BUS_WDATA[ACS_C1_BUSY] && busy && !set_done
     && state_ff != ACS_FINISH) |=> busy)
    else $error("busy cleared by software");
  a_strobe_dropped: assert property (
    (stb_rise && busy && state_ff != ACS_FINISH) |=>
      $stable(tick_total_ff) || $past(tick))
    else $error("strobe restarted a running conversion");
  a_manual_only: assert property (
    (!busy && !cfg_ff.auto_sample_enable && stb_rise && !sw_start)
      |=> !busy)
    else $error("strobe started conversion in standard mode");
  a_auto_start: assert property (
    (!busy && cfg_ff.auto_sample_enable && stb_rise) |=>
      state_ff == ACS_SAMPLE ##0 tick_total_ff == 5'h00)
    else $error("strobe edge missed in auto mode");
  a_done_clear: assert property (
    (wr_c1 && !BUS_WDATA[ACS_C1_DONE] && !set_done) |=> !done_ff)
    else $error("done flag not cleared");
  a_done_hold: assert property (
    (wr_c1 && BUS_WDATA[ACS_C1_DONE] && !done_ff && !set_done)
      |=> !done_ff)
    else $error("software set the done flag");
  a_gain_frozen: assert property (
    (busy && $past(busy)) |-> $stable(az_act_ff))
    else $error("autozero enable changed mid conversion");
  a_irq_level: assert property (
    (irq_en_ff && done_ff) |-> CONV_IRQ ##1 (CONV_IRQ || !done_ff
                                             || !irq_en_ff))
    else $error("interrupt not following done flag");

endmodule : acs_seq
`default_nettype wire

//--- acs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_far_model
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fire,
  input wire logic [7:0] level,
  input wire logic [7:0] sar_code,
  output logic strobe,
  output logic ref_clk,
  output logic comp_above
);
  logic [2:0] ref_cnt_ff;
  logic [2:0] strobe_cnt_ff;

  // Ideal comparator; input held steady for the whole conversion
  assign comp_above = (level >= sar_code);
  assign strobe = (strobe_cnt_ff != 3'h0);

  // Free running reference, period 16 clk, far below clk/4
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_ff <= 3'h0;
      ref_clk <= 1'b0;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 3'h1;
      if (ref_cnt_ff == 3'h7) ref_clk <= ~ref_clk;
    end
  end

  // Timer strobe: six clk high per request, so the edge is unambiguous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) strobe_cnt_ff <= 3'h0;
    else if (fire) strobe_cnt_ff <= 3'h6;
    else if (strobe_cnt_ff != 3'h0) strobe_cnt_ff <= strobe_cnt_ff - 3'h1;
  end
endmodule : acs_far_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acs_pkg::*;
  logic clk, resetn, bus_wr, fire, strobe, ref_in, comp, ref_out;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, sar, level, v;
  logic cmp_sel, amp_en, cur_en, az_act, last, ref_sel, smp, irq;
  logic [3:0] chan_act;
  int n_errors = 0;
  int checked = 0;
  int n0, s0, n, s, k;
  logic [7:0] pats [3] = '{8'hC3, 8'h3C, 8'h00};
  logic [7:0] lvls [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};

  acs_seq u_dut (.CLK(clk), .RESETN(resetn), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RDATA(bus_rdata),
    .TIMER_SAMPLE_STROBE(strobe), .REF_CLOCK_IN(ref_in), .COMP_ABOVE(comp),
    .REF_CLOCK_OUT(ref_out), .COMPARATOR_INPUT_SELECT(cmp_sel),
    .SPARE_AMP_ENABLE(amp_en), .CURRENT_SOURCE_ENABLE(cur_en),
    .AUTOZERO_ACTIVE(az_act), .REF_SELECT(ref_sel),
    .CHANNEL_ACTIVE(chan_act), .SAMPLE_PHASE(smp), .SAR_CODE(sar),
    .CONV_IRQ(irq));
  acs_far_model u_far (.clk(clk), .rstn(resetn), .fire(fire), .level(level),
    .sar_code(sar), .strobe(strobe), .ref_clk(ref_in), .comp_above(comp));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task chkb(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chkb

  // All bus tasks start and end 1 ns after a rising edge
  // Write strobe stays up so a following write needs no second edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk);
    #1;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    bus_wr = 1'b0;
    bus_addr = a;
    @(posedge clk);
    #1;
    d = bus_rdata;
  endtask : rd

  task idle(input int c);
    bus_wr = 1'b0;
    repeat (c) begin
      @(posedge clk);
      #1;
    end
  endtask : idle

  task pulse;
    fire = 1'b1;
    idle(1);
    fire = 1'b0;
  endtask : pulse

  // Busy is polled, not the done flag, for full completion
  task wait_idle;
    k = 0;
    rd(ACS_CTRL1_ADDR, v);
    while (v[ACS_C1_BUSY] === 1'b1 && k < 400) begin
      rd(ACS_CTRL1_ADDR, v);
      k++;
    end
    chkb(v[ACS_C1_BUSY], 1'b0);
  endtask : wait_idle

  // Software start, then count busy and sample cycles; zap writes busy 0
  task conv(input logic [7:0] ctl, input bit zap, output int nb,
            output int ns);
    nb = 0;
    ns = 0;
    wr(ACS_CTRL1_ADDR, ctl | 8'h20);
    bus_wr = 1'b0;
    while (nb < 400) begin
      @(posedge clk);
      #1;
      if (bus_rdata[ACS_C1_BUSY] !== 1'b1) break;
      nb++;
      if (smp === 1'b1) ns++;
      if (zap && nb == 3) bus_wdata = 8'h00;
      bus_wr = zap && nb == 3;
    end
    chkb(bus_rdata[ACS_C1_DONE], 1'b1);
    rd(ACS_RESULT_ADDR, v);
    chk8(v, level);
  endtask : conv

  task close_out;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    fire = 1'b0;
    level = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    rd(ACS_CTRL2_ADDR, v);
    chk8(v, ACS_CFG_RESET);
    rd(8'h55, v);
    chk8(v, 8'h00);
    for (k = 0; k < 3; k++) begin
      wr(ACS_CTRL2_ADDR, pats[k]);
      rd(ACS_CTRL2_ADDR, v);
      chk8(v, pats[k]);
      chkb(cmp_sel, pats[k][6]);
      chkb(amp_en, pats[k][5]);
      chkb(cur_en, pats[k][1]);
    end
    $display("test config done");
    for (k = 0; k < 2; k++) begin
      wr(ACS_CTRL2_ADDR, {k[0], 7'h00});
      idle(8);
      n = 0;
      last = ref_out;
      repeat (256) begin
        @(posedge clk);
        #1;
        if (ref_out === 1'b1 && last === 1'b0) n++;
        last = ref_out;
      end
      chk8(8'(n), 8'(16 >> k));
    end
    $display("test refclk done");
    for (k = 0; k < 4; k++) begin
      wr(ACS_CTRL2_ADDR, {4'h2, k[1:0], 2'b10});
      level = lvls[k];
      conv(8'h01, 1'b0, n, s);
      if (k == 0) begin
        n0 = n;
        s0 = s;
      end
      chk8(8'(n - n0), 8'(13 * ((1 << k) - 1)));
      chk8(8'(s - s0), 8'(4 * ((1 << k) - 1)));
    end
    wr(ACS_CTRL1_ADDR, 8'hC0);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_DONE], 1'b1);
    chkb(irq, 1'b1);
    wr(ACS_CTRL1_ADDR, 8'h50);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_DONE], 1'b0);
    chkb(irq, 1'b0);
    chkb(ref_sel, 1'b1);
    wr(ACS_CTRL1_ADDR, 8'hD0);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_DONE], 1'b0);
    $display("test standard done");
    wr(ACS_CTRL2_ADDR, 8'h01);
    level = 8'h3C;
    conv(8'h00, 1'b1, n, s);
    chk8(8'(n - n0), 8'h07);
    chk8(8'(s - s0), 8'h07);
    wr(ACS_CTRL1_ADDR, 8'h22);
    wr(ACS_CTRL2_ADDR, 8'h00);
    wr(ACS_CTRL1_ADDR, 8'h08);
    chkb(az_act, 1'b1);
    chk8({4'h0, chan_act}, 8'h02);
    rd(ACS_CTRL2_ADDR, v);
    chk8(v, 8'h00);
    wait_idle();
    wr(ACS_CTRL2_ADDR, 8'h20);
    conv(8'h08, 1'b0, n, s);
    chk8(8'(n - n0), 8'h00);
    chk8({4'h0, chan_act}, 8'h08);
    $display("test autozero done");
    pulse();
    idle(12);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b0);
    wr(ACS_CTRL2_ADDR, 8'h14);
    wr(ACS_CTRL1_ADDR, 8'h20);
    idle(2);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b0);
    level = 8'h81;
    pulse();
    idle(8);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b1);
    pulse();
    // A restart by this edge would still be busy when we look
    idle(25);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b0);
    wait_idle();
    rd(ACS_RESULT_ADDR, v);
    chk8(v, 8'h81);
    idle(30);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b0);
    $display("test auto done");
    // Reset in the middle of an auto conversion
    pulse();
    idle(8);
    rd(ACS_CTRL1_ADDR, v);
    chkb(v[ACS_C1_BUSY], 1'b1);
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    rd(ACS_CTRL1_ADDR, v);
    chk8(v, 8'h00);
    rd(ACS_CTRL2_ADDR, v);
    chk8(v, ACS_CFG_RESET);
    $display("test reset done");
    close_out();
  end
endmodule : tb
`default_nettype wire
